// ==== hdl/xbank_defines.svh ====
`ifndef XBANK_DEFINES_SVH
`define XBANK_DEFINES_SVH

`define CNT_MIN        16'h0001
`define CNT_MAX        16'h3000
`define SRC_MIN        16'h7000
`define SRC_MAX        16'h9999
`define SRC_BASE       14'd7000
`define CODE_MAIN      16'h0000
`define CODE_CUR       16'hE000
`define CODE_BANK_HI   12'hE0B
`define DEST_MAIN      8'h00
`define DEST_EXT       8'h80
`define BANKS_PRESENT  16'h0007
`define BANK_MAX       16'h000F
`define AREA_WORDS     15'd10000
`define XMEM_WORDS     12'd3000
`define RESET_BANK     4'h0

`endif

// ==== hdl/xbank_pkg.sv ====
package xbank_pkg;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_COPY,
        OP_PTR_SEL,
        OP_BANK_SEL
    } op_e;

    typedef struct packed {
        op_e         op;
        logic [15:0] arg_a;
        logic [15:0] arg_b;
        logic [15:0] arg_c;
    } instr_s;

    typedef struct packed {
        logic        we;
        logic [13:0] addr;
        logic [15:0] data;
    } dst_wr_s;
endpackage

// ==== hdl/xdm_mem.sv ====
`timescale 1ns/1ps
module xdm_mem (
    // Clock
    input  wire logic        ref_clk,
    // Write port
    input  wire logic        wr_en,
    input  wire logic [11:0] wr_addr,
    input  wire logic [15:0] wr_data,
    // Read port
    input  wire logic [11:0] rd_addr,
    output logic      [15:0] rd_data
);
    logic [15:0] mem [0:3071];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule

// ==== hdl/xbank_ctrl.sv ====
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "xbank_defines.svh"
module xbank_ctrl (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Instruction issue
    input  wire logic                  instr_valid,
    input  wire logic                  exec_cond,
    input  wire xbank_pkg::instr_s     instr,
    output logic                       instr_ready,
    output logic                       done,
    output logic                       error_flag,
    // Sequencer events
    input  wire logic                  scan_start,
    input  wire logic                  irq_entry,
    input  wire logic                  power_fail,
    // Expansion area configuration
    input  wire logic [11:0]           xmem_alloc_words,
    // Expansion memory loading port
    input  wire logic                  xmem_wr_en,
    input  wire logic [11:0]           xmem_wr_addr,
    input  wire logic [15:0]           xmem_wr_data,
    // Destination word writes
    output xbank_pkg::dst_wr_s         dst_wr,
    // Bank routing
    output logic [3:0]                 current_bank,
    output logic                       ptr_to_ext,
    output logic [3:0]                 ptr_bank,
    // Register port
    input  wire logic [3:0]            reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic [15:0]           reg_wdata,
    input  wire logic                  reg_rd,
    input  wire logic                  reg_tool,
    output logic [15:0]                reg_rdata
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PRIME,
        ST_COPY
    } state_e;

    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CTRL   = 4'h1;
    // Macro literal cannot be bit-selected directly
    localparam logic [15:0] BANK_MASK = `BANKS_PRESENT;

    state_e      state;
    logic [11:0] rd_ptr;
    logic [11:0] left;
    logic [13:0] wr_ptr;
    logic [15:0] mem_q;
    logic        power_sync1;
    logic        power_sync2;
    logic [15:0] ctrl_reg;
    logic [11:0] next_rd_ptr;

    function automatic logic is_bcd(input logic [15:0] v);
        is_bcd = (v[3:0] < 4'hA) && (v[7:4] < 4'hA) && (v[11:8] < 4'hA) && (v[15:12] < 4'hA);
    endfunction

    function automatic logic [13:0] bcd_bin(input logic [15:0] v);
        bcd_bin = 14'(v[15:12] * 1000) + 14'(v[11:8] * 100) + 14'(v[7:4] * 10) + 14'(v[3:0]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the presented instruction
    logic        cnt_ok;
    logic        src_ok;
    logic        alloc_ok;
    logic        dst_ok;
    logic [13:0] cnt_bin;
    logic [13:0] src_off;
    logic [14:0] src_end;
    logic [14:0] dst_end;
    logic        code_listed;
    logic        bank_ok;

    always_comb begin
        cnt_bin  = bcd_bin(instr.arg_a);
        src_off  = bcd_bin(instr.arg_b) - `SRC_BASE;
        cnt_ok   = is_bcd(instr.arg_a) && instr.arg_a >= `CNT_MIN
                   && instr.arg_a <= `CNT_MAX;
        src_ok   = is_bcd(instr.arg_b) && instr.arg_b >= `SRC_MIN
                   && instr.arg_b <= `SRC_MAX;
        src_end  = {1'b0, src_off} + {1'b0, cnt_bin};
        alloc_ok = src_end <= {3'b000, xmem_alloc_words};
        dst_end  = {1'b0, bcd_bin(instr.arg_c)} + {1'b0, cnt_bin};
        dst_ok   = is_bcd(instr.arg_c) && dst_end <= `AREA_WORDS;
        code_listed = instr.arg_a == `CODE_MAIN || instr.arg_a == `CODE_CUR
                      || instr.arg_a[15:4] == `CODE_BANK_HI;
        bank_ok  = instr.arg_a <= `BANK_MAX
                   && BANK_MASK[instr.arg_a[3:0]];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power interruption input is asynchronous
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            power_sync1 <= 1'b0;
            power_sync2 <= 1'b0;
        end else begin
            power_sync1 <= power_fail;
            power_sync2 <= power_sync1;
        end
    end

    // Copy stalls every instruction while running; under power loss
    // the copy also ignores pointer resets so it completes first
    assign instr_ready = state == ST_IDLE;

    wire take = instr_valid && instr_ready && exec_cond;
    wire copy_go = take && instr.op == xbank_pkg::OP_COPY
                   && cnt_ok && src_ok && alloc_ok && dst_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Copy sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state  <= ST_IDLE;
            rd_ptr <= 12'h000;
            left   <= 12'h000;
            wr_ptr <= 14'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (copy_go) begin
                        state  <= ST_PRIME;
                        rd_ptr <= src_off[11:0];
                        left   <= cnt_bin[11:0];
                        wr_ptr <= bcd_bin(instr.arg_c);
                    end
                end
                ST_PRIME: begin
                    state  <= ST_COPY;
                    rd_ptr <= next_rd_ptr;
                end
                ST_COPY: begin
                    rd_ptr <= next_rd_ptr;
                    wr_ptr <= wr_ptr + 14'd1;
                    left   <= left - 12'd1;
                    if (left == 12'd1) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign next_rd_ptr = rd_ptr + 12'd1;

    xdm_mem u_mem (
        .ref_clk (ref_clk),
        .wr_en   (xmem_wr_en && state == ST_IDLE),
        .wr_addr (xmem_wr_addr),
        .wr_data (xmem_wr_data),
        .rd_addr (state == ST_IDLE ? src_off[11:0] : rd_ptr),
        .rd_data (mem_q)
    );

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dst_wr <= '0;
        end else begin
            dst_wr.we   <= state == ST_COPY;
            dst_wr.addr <= wr_ptr;
            dst_wr.data <= mem_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion and error flag
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            done       <= 1'b0;
            error_flag <= 1'b0;
        end else begin
            done <= (take && !copy_go) || (state == ST_COPY && left == 12'd1);
            if (take) begin
                case (instr.op)
                    xbank_pkg::OP_COPY:
                        error_flag <= !(cnt_ok && src_ok && alloc_ok && dst_ok);
                    xbank_pkg::OP_PTR_SEL:
                        error_flag <= !code_listed;
                    xbank_pkg::OP_BANK_SEL:
                        error_flag <= !bank_ok;
                    default:
                        error_flag <= 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer destination and current bank
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ptr_to_ext <= 1'b0;
        end else if (!(power_sync2 && state != ST_IDLE)
                     && (scan_start || irq_entry)) begin
            ptr_to_ext <= 1'b0;
        end else if (take && instr.op == xbank_pkg::OP_PTR_SEL && code_listed) begin
            ptr_to_ext <= instr.arg_a != `CODE_MAIN;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            current_bank <= `RESET_BANK;
        end else if (take && instr.op == xbank_pkg::OP_PTR_SEL
                     && instr.arg_a[15:4] == `CODE_BANK_HI) begin
            current_bank <= instr.arg_a[3:0];
        end else if (take && instr.op == xbank_pkg::OP_BANK_SEL && bank_ok) begin
            current_bank <= instr.arg_a[3:0];
        end
    end

    assign ptr_bank = current_bank;

    ////////////////////////////////////////////////////////////////////////////
    // Register port
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_reg <= 16'h0000;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            ctrl_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_STATUS:
                    reg_rdata <= {(ptr_to_ext && !reg_tool) ? `DEST_EXT : `DEST_MAIN,
                                  4'h0, current_bank};
                REG_CTRL:
                    reg_rdata <= ctrl_reg;
                default:
                    reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

// ==== dv/xbank_ctrl_sva.sv ====
`timescale 1ns/1ps
module xbank_ctrl_sva (
    // Clock and reset
    input wire logic               ref_clk,
    input wire logic               sys_rst,
    // Instruction issue and events
    input wire logic               instr_valid,
    input wire logic               exec_cond,
    input wire xbank_pkg::instr_s  instr,
    input wire logic               instr_ready,
    input wire logic               done,
    input wire logic               error_flag,
    input wire logic               scan_start,
    input wire logic               irq_entry,
    // Routing and status
    input wire xbank_pkg::dst_wr_s dst_wr,
    input wire logic [3:0]         current_bank,
    input wire logic               ptr_to_ext,
    input wire logic [3:0]         ptr_bank,
    input wire logic [3:0]         reg_addr,
    input wire logic               reg_rd,
    input wire logic               reg_tool,
    input wire logic [15:0]        reg_rdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire take = instr_valid && instr_ready && exec_cond;
    wire quiet = !scan_start && !irq_entry;
    ////////////////////////////////////////////////////////////////////////
    a_cond_off: assert property (
        instr_valid && instr_ready && !exec_cond && !done |=> !done && !dst_wr.we)
        else $error("instruction acted without condition");
    a_copy_walk: assert property (
        dst_wr.we && !done |=> dst_wr.we && dst_wr.addr == $past(dst_wr.addr) + 14'h1)
        else $error("copy writes not ascending");
    a_count_bad: assert property (
        take && instr.op == xbank_pkg::OP_COPY && instr.arg_a == 16'h3001 |=> done && error_flag)
        else $error("count over limit accepted");
    a_src_bad: assert property (
        take && instr.op == xbank_pkg::OP_COPY && instr.arg_b == 16'h6999 |=> done && error_flag)
        else $error("source below limit accepted");
    a_bad_code: assert property (
        take && quiet && instr.op == xbank_pkg::OP_PTR_SEL && instr.arg_a[15:4] == 12'hE0C
        |=> error_flag && $stable(ptr_to_ext)) else $error("unlisted code changed route");
    a_bank_route: assert property (
        take && quiet && instr.op == xbank_pkg::OP_PTR_SEL && instr.arg_a[15:4] == 12'hE0B
        && instr.arg_a[3:0] < 4'h3 |=> ptr_to_ext && current_bank == $past(instr.arg_a[3:0]))
        else $error("bank code did not route");
    a_scan_main: assert property (
        !quiet && instr_ready && !take |=> !ptr_to_ext) else $error("pointer not restored");
    a_status_rd: assert property (
        reg_rd && !reg_tool && reg_addr == 4'h0 |=> reg_rdata ==
        {$past(ptr_to_ext) ? 8'h80 : 8'h00, 4'h0, $past(current_bank)})
        else $error("status word wrong");
    a_tool_rd: assert property (
        reg_rd && reg_tool && reg_addr == 4'h0 |=> reg_rdata[15:8] == 8'h00)
        else $error("tool read shows extension");
    a_absent_bank: assert property (
        take && instr.op == xbank_pkg::OP_BANK_SEL && instr.arg_a == 16'h0003
        |=> error_flag && $stable(current_bank)) else $error("absent bank taken");
    a_ptr_bank: assert property (ptr_bank == current_bank)
        else $error("pointer bank differs");
endmodule
////////////////////////////////////////////////////////////////////////
bind xbank_ctrl xbank_ctrl_sva chk_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .exec_cond(exec_cond),
    .instr(instr), .instr_ready(instr_ready), .done(done), .error_flag(error_flag),
    .scan_start(scan_start), .irq_entry(irq_entry), .dst_wr(dst_wr),
    .current_bank(current_bank), .ptr_to_ext(ptr_to_ext), .ptr_bank(ptr_bank),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_tool(reg_tool), .reg_rdata(reg_rdata)
);

// ==== dv/extended_data_memory_bank_access_tb.sv ====
`timescale 1ns/1ps
module extended_data_memory_bank_access_tb;
    logic ref_clk, sys_rst, instr_valid, exec_cond, instr_ready, done, error_flag;
    logic scan_start, irq_entry, power_fail, xmem_wr_en, ptr_to_ext, reg_wr, reg_rd, reg_tool;
    logic [11:0] xmem_alloc_words, xmem_wr_addr;
    logic [15:0] xmem_wr_data, reg_wdata, reg_rdata, v;
    logic [3:0]  current_bank, ptr_bank, reg_addr;
    logic        fin;
    xbank_pkg::instr_s  instr;
    xbank_pkg::dst_wr_s dst_wr;
    xbank_pkg::dst_wr_s wr_q[$];
    int num_errors, checks_done;
    xbank_ctrl dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .exec_cond(exec_cond), .instr(instr), .instr_ready(instr_ready), .done(done),
        .error_flag(error_flag), .scan_start(scan_start), .irq_entry(irq_entry),
        .power_fail(power_fail), .xmem_alloc_words(xmem_alloc_words), .xmem_wr_en(xmem_wr_en),
        .xmem_wr_addr(xmem_wr_addr), .xmem_wr_data(xmem_wr_data), .dst_wr(dst_wr),
        .current_bank(current_bank), .ptr_to_ext(ptr_to_ext), .ptr_bank(ptr_bank),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_tool(reg_tool), .reg_rdata(reg_rdata));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Copies log every destination write until done, capped above the largest count
    task automatic run(input xbank_pkg::op_e op, input logic [15:0] a, b, input logic cond);
        wr_q.delete();
        fin = 1'b0;
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        exec_cond <= cond;
        instr <= '{op, a, b, 16'h0010};
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        for (int n = 0; n < 3100 && !fin && (cond || n < 5); n++) begin
            @(negedge ref_clk);
            if (dst_wr.we === 1'b1) wr_q.push_back(dst_wr);
            fin = (done === 1'b1);
        end
    endtask
    task automatic expect_err(input xbank_pkg::op_e op, input logic [15:0] a, b);
        run(op, a, b, 1'b1);
        check(16'({fin, error_flag}), 16'h0003);
    endtask
    task automatic rd(input logic [3:0] a, input logic tool);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        reg_tool <= tool;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask
    task automatic pulse(input logic irq);
        @(posedge ref_clk);
        if (irq) irq_entry <= 1'b1; else scan_start <= 1'b1;
        @(posedge ref_clk);
        {irq_entry, scan_start} <= 2'b00;
        @(negedge ref_clk);
        check(16'(ptr_to_ext), 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_refuse();
        expect_err(xbank_pkg::OP_COPY, 16'h0000, 16'h7000);
        expect_err(xbank_pkg::OP_COPY, 16'h3001, 16'h7000);
        expect_err(xbank_pkg::OP_COPY, 16'h001A, 16'h7000);
        expect_err(xbank_pkg::OP_COPY, 16'h0001, 16'h6999);
        expect_err(xbank_pkg::OP_COPY, 16'h0001, 16'h7A00);
        expect_err(xbank_pkg::OP_COPY, 16'h0001, 16'h7020);
    endtask
    task automatic t_copy();
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            xmem_wr_en <= 1'b1;
            xmem_wr_addr <= 12'(i);
            xmem_wr_data <= 16'hA000 + 16'(i);
        end
        @(posedge ref_clk);
        xmem_wr_en <= 1'b0;
        run(xbank_pkg::OP_COPY, 16'h0003, 16'h7002, 1'b0);
        check(16'(wr_q.size()) + 16'(fin), 16'h0000);
        run(xbank_pkg::OP_COPY, 16'h0003, 16'h7002, 1'b1);
        check(16'({fin, error_flag}), 16'h0002);
        check(16'(wr_q.size()), 16'h0003);
        foreach (wr_q[i]) begin
            check(16'(wr_q[i].addr), 16'h000A + 16'(i));
            check(wr_q[i].data, 16'hA002 + 16'(i));
        end
    endtask
    task automatic t_route();
        for (int b = 0; b < 3; b++) begin
            run(xbank_pkg::OP_PTR_SEL, 16'hE0B0 + 16'(b), 16'h0000, 1'b1);
            check(16'(current_bank), 16'(b));
            rd(4'h0, 1'b0);
            check(v, 16'h8000 + 16'(b));
            rd(4'h0, 1'b1);
            check(v, 16'(b));
        end
        expect_err(xbank_pkg::OP_PTR_SEL, 16'hE0C1, 16'h0000);
        check(16'({ptr_to_ext, current_bank}), 16'h0012);
        run(xbank_pkg::OP_PTR_SEL, 16'h0000, 16'h0000, 1'b1);
        check(16'({error_flag, ptr_to_ext}), 16'h0000);
        run(xbank_pkg::OP_PTR_SEL, 16'hE000, 16'h0000, 1'b1);
        check(16'({ptr_to_ext, current_bank}), 16'h0012);
        pulse(1'b0);
        run(xbank_pkg::OP_PTR_SEL, 16'hE000, 16'h0000, 1'b1);
        pulse(1'b1);
    endtask
    task automatic t_bank();
        run(xbank_pkg::OP_BANK_SEL, 16'h0001, 16'h0000, 1'b1);
        check(16'({error_flag, current_bank}), 16'h0001);
        expect_err(xbank_pkg::OP_BANK_SEL, 16'h0003, 16'h0000);
        expect_err(xbank_pkg::OP_BANK_SEL, 16'h0010, 16'h0000);
        check(16'({current_bank, ptr_bank}), 16'h0011);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= 4'h1;
        reg_wdata <= 16'h5A3C;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        rd(4'h1, 1'b0);
        check(v, 16'h5A3C);
        rd(4'h7, 1'b0);
        check(v, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        {sys_rst, instr_valid, exec_cond, scan_start, irq_entry, power_fail} = 6'b100000;
        {xmem_wr_en, reg_wr, reg_rd, reg_tool, xmem_wr_addr, xmem_wr_data} = '0;
        {reg_wdata, reg_addr, instr} = '0;
        xmem_alloc_words = 12'h010;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_refuse();
        t_copy();
        t_route();
        t_bank();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        stop_test();
    end
endmodule
